// ---- fan_speed_curve_and_fault_logic.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "fan_curve_regs.svh"

module fan_speed_curve_and_fault_logic #(
	parameter int PW = 24,
	parameter logic [63:0] LOCK_CYC = `LOCK_CYC,
	parameter logic [63:0] COAST_CYC = `COAST_CYC
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire logic SPD_IN,
	input wire fan_curve_pkg::fault_in_s FAULT_IN,
	input wire fan_curve_pkg::curve_cfg_s CFG,
	input wire logic [7:0] RD_ADDR,
	output logic [15:0] RD_DATA,
	output logic DRIVE_EN,
	output logic [17:0] SPEED_TARGET,
	output logic [8:0] DEMAND,
	output logic OPEN_LOOP,
	output logic REVERSE,
	output logic OFF_LEVEL_MODE,
	output logic [7:0] OFF_LEVEL_PWM,
	output logic COASTING,
	output logic LOCK_ACTIVE,
	output logic CURRENT_LIMIT,
	output logic FAULT_OUT_N_O,
	output logic FAULT_OUT_N_OE
);

	localparam int NF = $bits(fan_curve_pkg::fault_in_s);
	localparam int NQ = 7;
	localparam logic [7:0] BLANK = 8'(`BLANK_CYC);
	localparam logic [PW-1:0] CNT_MAX = {PW{1'b1}};

	// Input synchronisers
	logic [NF:0] sync_a;
	logic [NF:0] sync_b;
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {SPD_IN, FAULT_IN};
			sync_b <= sync_a;
		end
	end
	fan_curve_pkg::fault_in_s flt;
	wire spd_s = sync_b[NF];
	assign flt = sync_b[NF-1:0];

	// Duty measurement
	logic spd_d;
	logic [PW-1:0] cnt_period;
	logic [PW-1:0] cnt_high;
	logic [PW-1:0] lat_period;
	logic [PW-1:0] lat_high;
	logic div_busy;
	logic [3:0] div_bit;
	logic [8:0] quot;
	logic [8:0] demand;
	wire spd_rise = spd_s & ~spd_d;
	wire cnt_timeout = (cnt_period == CNT_MAX);
	wire [8:0] trial = quot | (9'h001 << div_bit);
	wire [PW+8:0] prod = {9'h000, lat_period} * {{PW{1'b0}}, trial};
	wire [PW+8:0] num = {9'h000, lat_high} * {{PW{1'b0}}, `DUTY_FULL};
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			spd_d <= 1'b0;
			cnt_period <= '0;
			cnt_high <= '0;
			lat_period <= '0;
			lat_high <= '0;
			div_busy <= 1'b0;
			div_bit <= 4'h0;
			quot <= 9'h000;
			demand <= 9'h000;
		end else begin
			spd_d <= spd_s;
			if (spd_rise && cnt_period != '0) begin
				lat_period <= cnt_period;
				lat_high <= cnt_high;
				cnt_period <= PW'(1);
				cnt_high <= PW'(1);
				div_busy <= 1'b1;
				div_bit <= 4'h8;
				quot <= 9'h000;
			end else if (cnt_timeout) begin
				demand <= spd_s ? `DUTY_FULL : 9'h000;
			end else begin
				cnt_period <= cnt_period + PW'(1);
				cnt_high <= cnt_high + PW'(spd_s);
			end
			if (div_busy && !spd_rise) begin
				if (prod <= num) begin
					quot <= trial;
				end
				if (div_bit == 4'h0) begin
					div_busy <= 1'b0;
					demand <= (prod <= num) ? trial : quot;
				end else begin
					div_bit <= div_bit - 4'h1;
				end
			end
		end
	end

	// Curve mapping
	wire [8:0] d_inv = CFG.duty_invert ? (`DUTY_FULL - demand) : demand;
	wire clamp_on = (CFG.min_duty_clamp != 8'h00);
	wire [8:0] clamp9 = {1'b0, CFG.min_duty_clamp};
	wire [8:0] d_cl = (clamp_on && d_inv < clamp9) ? clamp9 : d_inv;
	wire dir_fwd = (d_cl >= `DUTY_HALF);
	wire [8:0] half_mag = dir_fwd ? (d_cl - `DUTY_HALF) : (`DUTY_HALF_LO - d_cl);
	wire [8:0] mag = CFG.half_duty_direction ? half_mag : d_cl;
	wire [8:0] en_thr = {1'b0, CFG.duty_enable_threshold};
	wire [8:0] dis_thr = {1'b0, CFG.duty_disable_threshold};
	wire [9:0] mag_hys = {1'b0, mag} + 10'(`ONOFF_HYS);
	wire on_reach = (mag >= en_thr);
	wire off_plain = (mag <= dis_thr) && (en_thr != 9'h000);
	wire off_win = (mag_hys <= {1'b0, dis_thr});
	wire off_hit = CFG.onoff_window_control ? off_win : off_plain;
	wire [8:0] max_thr = `DUTY_FULL - {2'b00, CFG.max_duty_code, 3'b000};
	// Widen before adding one so that code 15 gives sixteen steps, not zero
	wire [8:0] max_hys = ({5'h00, CFG.max_duty_hysteresis} + 9'h001) * 9'(`MAXHYS_STEP);
	wire [9:0] max_low = {1'b0, max_thr} - {1'b0, max_hys};
	wire max_en = (CFG.max_duty_code != 4'h0);

	logic curve_on;
	logic above_max;
	wire next_curve_on = curve_on ? !off_hit : on_reach;
	wire next_above_max = !max_en ? 1'b0 :
		above_max ? ({1'b0, mag} >= max_low) : (mag >= max_thr);
	wire [8:0] mag_sp = (above_max && CFG.max_duty_behaviour_option) ? max_thr : mag;
	wire [22:0] slope_prod = {9'h000, CFG.speed_slope_value} * {14'h0000, mag_sp};
	wire [16:0] slope_term = slope_prod[22:`SLOPE_SHIFT];
	wire [17:0] slope_adj = CFG.half_duty_direction ? {slope_term, 1'b0} : {1'b0, slope_term};
	wire [18:0] speed_sum = {1'b0, slope_adj} + {7'h00, CFG.min_speed_setpoint};
	wire [17:0] speed_sat = speed_sum[18] ? `SPEED_MAX : speed_sum[17:0];
	wire off_level = CFG.onoff_window_control && !curve_on;
	wire want_run = curve_on || CFG.onoff_window_control;
	wire want_rev = CFG.half_duty_direction ? !dir_fwd :
		(off_level && CFG.reverse_below_off_option);

	// Qualification filters: overcurrent bits and current-limit sense
	wire [NQ-1:0] q_raw = {flt.low_side_sense, flt.overcurrent_protection};
	logic [NQ-1:0] q_ok;
	genvar gi;
	generate
		for (gi = 0; gi < NQ; gi++) begin : g_blank
			logic [7:0] bcnt;
			always_ff @(posedge MCLK or negedge RESET_N) begin
				if (!RESET_N) begin
					bcnt <= 8'h00;
				end else if (!q_raw[gi]) begin
					bcnt <= 8'h00;
				end else if (bcnt != BLANK) begin
					bcnt <= bcnt + 8'h01;
				end
			end
			assign q_ok[gi] = q_raw[gi] && (bcnt == BLANK);
		end
	endgenerate

	// Fault handling
	logic [5:0] ocp_flag;
	logic [6:0] sync_d;
	logic ov_d;
	logic run_cmd_d;
	logic lock_act;
	logic [63:0] lock_cnt;
	wire lock_done = lock_act && (lock_cnt >= LOCK_CYC - 64'd1);
	wire ocp_any = |ocp_flag;
	wire [5:0] ocp_new = q_ok[5:0] & ~ocp_flag;
	wire onoff_cycle = want_run && !run_cmd_d;
	wire [5:0] ocp_clr = CFG.overcurrent_latch_option ? {6{onoff_cycle}} : {6{lock_done}};
	wire sync_rise = |(flt.sync_loss & ~sync_d);
	wire ov_rise = flt.overvoltage && !ov_d && CFG.overvoltage_lock_option;
	wire ocp_retry = (|ocp_new) && !CFG.overcurrent_latch_option;
	wire lock_start = sync_rise || ov_rise || ocp_retry;
	wire fault_stop = flt.undervoltage || flt.thermal_shutdown || flt.charge_pump_uv
		|| flt.overvoltage || ocp_any || lock_act;
	wire fault_pin = flt.undervoltage || flt.thermal_shutdown || flt.charge_pump_uv
		|| flt.overvoltage || ocp_any || (|flt.sync_loss) || lock_act;
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ocp_flag <= 6'h00;
			sync_d <= 7'h00;
			ov_d <= 1'b0;
			run_cmd_d <= 1'b0;
			lock_act <= 1'b0;
			lock_cnt <= 64'd0;
		end else begin
			ocp_flag <= q_ok[5:0] | (ocp_flag & ~ocp_clr);
			sync_d <= flt.sync_loss;
			ov_d <= flt.overvoltage;
			run_cmd_d <= want_run;
			if (lock_start) begin
				lock_act <= 1'b1;
				lock_cnt <= 64'd0;
			end else if (lock_done) begin
				lock_act <= 1'b0;
			end else if (lock_act) begin
				lock_cnt <= lock_cnt + 64'd1;
			end
		end
	end

	// Run, stop and coast sequencing
	fan_curve_pkg::motor_state_e mstate;
	fan_curve_pkg::motor_state_e next_mstate;
	logic cur_rev;
	logic [63:0] coast_cnt;
	wire coast_done = (coast_cnt >= COAST_CYC - 64'd1);
	always_comb begin
		next_mstate = mstate;
		case (mstate)
			fan_curve_pkg::ST_STOP: begin
				if (want_run && !fault_stop) begin
					next_mstate = fan_curve_pkg::ST_RUN;
				end
			end
			fan_curve_pkg::ST_RUN: begin
				if (!want_run || fault_stop) begin
					next_mstate = fan_curve_pkg::ST_STOP;
				end else if (want_rev != cur_rev) begin
					next_mstate = fan_curve_pkg::ST_COAST;
				end
			end
			fan_curve_pkg::ST_COAST: begin
				if (coast_done) begin
					next_mstate = fan_curve_pkg::ST_STOP;
				end
			end
			default: begin
				next_mstate = fan_curve_pkg::ST_STOP;
			end
		endcase
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mstate <= fan_curve_pkg::ST_STOP;
			cur_rev <= 1'b0;
			coast_cnt <= 64'd0;
			curve_on <= 1'b0;
			above_max <= 1'b0;
		end else begin
			mstate <= next_mstate;
			curve_on <= next_curve_on;
			above_max <= next_above_max;
			coast_cnt <= (mstate == fan_curve_pkg::ST_COAST) ? coast_cnt + 64'd1 : 64'd0;
			if (mstate == fan_curve_pkg::ST_STOP) begin
				cur_rev <= want_rev;
			end
		end
	end

	// Readback and outputs
	wire [15:0] rb_main = {6'h00, flt.overvoltage, flt.undervoltage, flt.charge_pump_uv,
		flt.thermal_shutdown, ocp_flag};
	wire [15:0] rb_sync = {9'h000, flt.sync_loss};
	wire [15:0] rd_mux = (RD_ADDR == `REG_FAULT_MAIN) ? rb_main :
		(RD_ADDR == `REG_SYNC_LOSS) ? rb_sync : 16'h0000;
	wire run_now = (mstate == fan_curve_pkg::ST_RUN) && !fault_stop;

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			RD_DATA <= `RD_RESET;
			DRIVE_EN <= 1'b0;
			SPEED_TARGET <= 18'h00000;
			DEMAND <= 9'h000;
			OPEN_LOOP <= 1'b0;
			REVERSE <= 1'b0;
			OFF_LEVEL_MODE <= 1'b0;
			OFF_LEVEL_PWM <= 8'h00;
			COASTING <= 1'b0;
			LOCK_ACTIVE <= 1'b0;
			CURRENT_LIMIT <= 1'b0;
			FAULT_OUT_N_O <= 1'b0;
			FAULT_OUT_N_OE <= 1'b0;
		end else begin
			RD_DATA <= rd_mux;
			DRIVE_EN <= run_now;
			SPEED_TARGET <= speed_sat;
			DEMAND <= mag;
			OPEN_LOOP <= above_max && !CFG.max_duty_behaviour_option;
			REVERSE <= cur_rev;
			OFF_LEVEL_MODE <= off_level;
			OFF_LEVEL_PWM <= CFG.off_level_pwm;
			COASTING <= (mstate == fan_curve_pkg::ST_COAST);
			LOCK_ACTIVE <= lock_act;
			CURRENT_LIMIT <= q_ok[6];
			FAULT_OUT_N_O <= 1'b0;
			FAULT_OUT_N_OE <= fault_pin;
		end
	end

endmodule : fan_speed_curve_and_fault_logic
`default_nettype wire

// ---- fan_curve_regs.svh ----
`ifndef FAN_CURVE_REGS_SVH
`define FAN_CURVE_REGS_SVH

// Readback register offsets
`define REG_FAULT_MAIN 8'h93
`define REG_SYNC_LOSS 8'h94

// Field positions in the main fault and sync-loss readback words
`define FLT_OV_BIT 9
`define FLT_UV_BIT 8
`define FLT_CP_BIT 7
`define FLT_TSD_BIT 6
`define FLT_OCP_MSB 5
`define FLT_SYNC_MSB 6
`define RD_RESET 16'h0000

// Clock and timing
`define CLK_PERIOD_PS 4000
`define BLANK_TIME_NS 640
`define BLANK_CYC ((`BLANK_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define LOCK_TIME_MS 5000
`define LOCK_CYC ((64'd`LOCK_TIME_MS * 64'd1000000000) / 64'd`CLK_PERIOD_PS)
`define COAST_TIME_MS 100
`define COAST_CYC ((64'd`COAST_TIME_MS * 64'd1000000000) / 64'd`CLK_PERIOD_PS)

// Demand scale
`define DUTY_FULL 9'h1ff
`define DUTY_HALF 9'h100
`define DUTY_HALF_LO 9'h0ff
`define MAXDUTY_STEP 4'h8
`define ONOFF_HYS_PERMIL 8
`define ONOFF_HYS ((`ONOFF_HYS_PERMIL * 511) / 1000)
`define MAXHYS_STEP_PERMIL 4
`define MAXHYS_STEP ((`MAXHYS_STEP_PERMIL * 511) / 1000)
`define SLOPE_SHIFT 6
`define SPEED_MAX 18'h3ffff

`endif

// ---- fan_curve_pkg.sv ----
package fan_curve_pkg;

	typedef struct packed {
		logic [11:0] min_speed_setpoint;
		logic [13:0] speed_slope_value;
		logic [7:0] duty_enable_threshold;
		logic [7:0] duty_disable_threshold;
		logic [7:0] off_level_pwm;
		logic [7:0] min_duty_clamp;
		logic [3:0] max_duty_code;
		logic [3:0] max_duty_hysteresis;
		logic onoff_window_control;
		logic reverse_below_off_option;
		logic duty_invert;
		logic max_duty_behaviour_option;
		logic half_duty_direction;
		logic overcurrent_latch_option;
		logic overvoltage_lock_option;
	} curve_cfg_s;

	typedef struct packed {
		logic overvoltage;
		logic undervoltage;
		logic charge_pump_uv;
		logic thermal_shutdown;
		logic low_side_sense;
		logic [5:0] overcurrent_protection;
		logic [6:0] sync_loss;
	} fault_in_s;

	typedef enum logic [1:0] {
		ST_STOP = 2'b00,
		ST_RUN = 2'b01,
		ST_COAST = 2'b10
	} motor_state_e;

endpackage : fan_curve_pkg

// ---- fan_curve_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module fan_curve_sva #(
	parameter logic [63:0] LOCK_CYC = 64'd200
) (
	input wire logic MCLK,
	input wire logic RESET_N,
	input wire fan_curve_pkg::fault_in_s FAULT_IN,
	input wire fan_curve_pkg::curve_cfg_s CFG,
	input wire logic [7:0] RD_ADDR,
	input wire logic [15:0] RD_DATA,
	input wire logic DRIVE_EN,
	input wire logic OFF_LEVEL_MODE,
	input wire logic COASTING,
	input wire logic LOCK_ACTIVE,
	input wire logic CURRENT_LIMIT,
	input wire logic FAULT_OUT_N_OE
);
	logic [7:0] lss_run;
	logic [7:0] ocp_run;
	logic [15:0] lock_run;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESET_N);
	// Saturating run lengths of sense input and any overcurrent bit; non-saturating lock span count
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			lss_run <= 8'h00;
			ocp_run <= 8'h00;
			lock_run <= 16'h0000;
		end else begin
			lss_run <= FAULT_IN.low_side_sense ? lss_run + {7'h00, lss_run != 8'hff} : 8'h00;
			ocp_run <= |FAULT_IN.overcurrent_protection ? ocp_run + {7'h00, ocp_run != 8'hff} : 8'h00;
			lock_run <= LOCK_ACTIVE ? lock_run + 16'h0001 : 16'h0000;
		end
	end
	a_uv_pin_low: assert property (FAULT_IN.undervoltage [*5] |-> FAULT_OUT_N_OE)
		else $error("fault pin idle in undervoltage");
	a_tsd_drive_off: assert property (FAULT_IN.thermal_shutdown [*5] |-> !DRIVE_EN)
		else $error("drive on in thermal shutdown");
	a_cl_blanking: assert property ($rose(CURRENT_LIMIT) |-> $past(lss_run, 3) >= 8'd158)
		else $error("current limit on short pulse");
	a_ocp_drive_off: assert property (ocp_run >= 8'd166 |-> !DRIVE_EN)
		else $error("drive on in overcurrent");
	a_sync_lock_start: assert property ($rose(|FAULT_IN.sync_loss) |-> ##[1:8] LOCK_ACTIVE)
		else $error("sync loss without lock");
	a_lock_holds_off: assert property (LOCK_ACTIVE && $past(LOCK_ACTIVE) |-> !DRIVE_EN)
		else $error("drive on during lock");
	a_lock_span_max: assert property (lock_run <= LOCK_CYC[15:0] + 16'h0001)
		else $error("lock too long");
	a_sync_readback: assert property ((RD_ADDR == 8'h94 && $stable(FAULT_IN.sync_loss)) [*5]
		|=> RD_DATA == {9'h000, $past(FAULT_IN.sync_loss)})
		else $error("sync readback wrong");
	a_ov_readback: assert property ((RD_ADDR == 8'h93 && $stable(FAULT_IN.overvoltage)) [*5]
		|=> RD_DATA[9] == $past(FAULT_IN.overvoltage))
		else $error("overvoltage readback wrong");
	a_offlevel_window: assert property (OFF_LEVEL_MODE |-> $past(CFG.onoff_window_control))
		else $error("off level outside window mode");
	a_coast_drive_off: assert property (COASTING && $past(COASTING) |-> !DRIVE_EN)
		else $error("drive on while coasting");
	c_lock: cover property ($rose(LOCK_ACTIVE));
	c_coast: cover property ($rose(COASTING));
	c_limit: cover property ($rose(CURRENT_LIMIT));
endmodule : fan_curve_sva
bind fan_speed_curve_and_fault_logic fan_curve_sva #(.LOCK_CYC(LOCK_CYC)) sva_i (
	.MCLK(MCLK), .RESET_N(RESET_N), .FAULT_IN(FAULT_IN), .CFG(CFG), .RD_ADDR(RD_ADDR),
	.RD_DATA(RD_DATA), .DRIVE_EN(DRIVE_EN), .OFF_LEVEL_MODE(OFF_LEVEL_MODE),
	.COASTING(COASTING), .LOCK_ACTIVE(LOCK_ACTIVE), .CURRENT_LIMIT(CURRENT_LIMIT),
	.FAULT_OUT_N_OE(FAULT_OUT_N_OE));
`default_nettype wire

// ---- pwm_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module pwm_host_model (
	input wire logic clk,
	input wire logic [8:0] high_cnt,
	output var logic pwm
);
	logic [8:0] phase = 9'h000;
	initial pwm = 1'b0;
	// Period of 511 cycles, so the measured demand equals the high count
	always @(posedge clk) begin
		#1;
		phase <= (phase == 9'h1fe) ? 9'h000 : phase + 9'h001;
		pwm <= phase < high_cnt;
	end
endmodule : pwm_host_model
`default_nettype wire

// ---- fan_speed_curve_and_fault_logic_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module fan_speed_curve_and_fault_logic_bench;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic spd;
	logic [8:0] hi = 9'h000;
	fan_curve_pkg::fault_in_s flt = '0;
	fan_curve_pkg::curve_cfg_s cfg = '0;
	logic [7:0] addr = 8'h00;
	logic [15:0] rd;
	logic de, ol, rv, olm, co, la, cl, foe, fo;
	logic [17:0] spdt;
	logic [8:0] dem;
	logic [7:0] olp;
	int miscompares = 0;
	int checks_done = 0;
	always #2 mclk = ~mclk;
	pwm_host_model host (.clk(mclk), .high_cnt(hi), .pwm(spd));
	fan_speed_curve_and_fault_logic #(.PW(12), .LOCK_CYC(64'd200), .COAST_CYC(64'd50)) dut (
		.MCLK(mclk), .RESET_N(reset_n), .SPD_IN(spd), .FAULT_IN(flt), .CFG(cfg),
		.RD_ADDR(addr), .RD_DATA(rd), .DRIVE_EN(de), .SPEED_TARGET(spdt), .DEMAND(dem),
		.OPEN_LOOP(ol), .REVERSE(rv), .OFF_LEVEL_MODE(olm), .OFF_LEVEL_PWM(olp),
		.COASTING(co), .LOCK_ACTIVE(la), .CURRENT_LIMIT(cl), .FAULT_OUT_N_O(fo),
		.FAULT_OUT_N_OE(foe));
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		addr = a;
		tick(2);
		chk({2'b00, rd}, {2'b00, exp});
	endtask : rd_chk
	task automatic duty(input logic [8:0] h);
		hi = h;
		tick(1600);
	endtask : duty
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	initial begin
		#300000;
		miscompares++;
		finish_test();
	end
	initial begin
		tick(3);
		reset_n = 1'b1;
		rd_chk(8'h55, 16'h0000);
		rd_chk(8'h93, 16'h0000);
		cfg.min_speed_setpoint = 12'h064;
		cfg.speed_slope_value = 14'h0040;
		cfg.duty_enable_threshold = 8'h14;
		cfg.duty_disable_threshold = 8'h0a;
		duty(9'h0c8);
		chk(dem, 9'h0c8);
		chk(spdt, 18'h0012c);
		chk(de, 1'b1);
		duty(9'h005);
		chk(de, 1'b0);
		duty(9'h00f);
		chk(de, 1'b0);
		cfg.duty_invert = 1'b1;
		duty(9'h0c8);
		chk(spdt, 18'h0019b);
		cfg.duty_invert = 1'b0;
		duty(9'h005);
		cfg.min_duty_clamp = 8'h32;
		duty(9'h00f);
		chk(dem, 9'h032);
		chk(de, 1'b1);
		cfg.min_duty_clamp = 8'h00;
		cfg.max_duty_code = 4'h2;
		duty(9'h1f9);
		chk(ol, 1'b1);
		duty(9'h1ee);
		chk(ol, 1'b1);
		duty(9'h1ec);
		chk(ol, 1'b0);
		cfg.max_duty_behaviour_option = 1'b1;
		duty(9'h1f9);
		chk(ol, 1'b0);
		chk(spdt, 18'h00253);
		cfg.max_duty_behaviour_option = 1'b0;
		cfg.max_duty_code = 4'h0;
		duty(9'h1f9);
		chk(ol, 1'b0);
		cfg.onoff_window_control = 1'b1;
		cfg.off_level_pwm = 8'h40;
		cfg.reverse_below_off_option = 1'b1;
		duty(9'h005);
		chk(olm, 1'b1);
		chk(de, 1'b1);
		chk(olp, 8'h40);
		chk(rv, 1'b1);
		cfg.onoff_window_control = 1'b0;
		cfg.reverse_below_off_option = 1'b0;
		cfg.half_duty_direction = 1'b1;
		duty(9'h164);
		chk(rv, 1'b0);
		chk(spdt, 18'h0012c);
		hi = 9'h064;
		for (int i = 0; i < 2000 && co !== 1'b1; i++)
			tick(1);
		tick(2);
		chk(co, 1'b1);
		chk(de, 1'b0);
		tick(1600);
		chk(rv, 1'b1);
		chk(spdt, 18'h0019a);
		cfg.half_duty_direction = 1'b0;
		duty(9'h0c8);
		flt.undervoltage = 1'b1;
		tick(5);
		chk(foe, 1'b1);
		chk(fo, 1'b0);
		rd_chk(8'h93, 16'h0100);
		flt.undervoltage = 1'b0;
		flt.thermal_shutdown = 1'b1;
		tick(5);
		chk(de, 1'b0);
		rd_chk(8'h93, 16'h0040);
		flt.thermal_shutdown = 1'b0;
		tick(10);
		chk(de, 1'b1);
		flt.charge_pump_uv = 1'b1;
		tick(5);
		chk(foe, 1'b1);
		chk(de, 1'b0);
		rd_chk(8'h93, 16'h0080);
		flt.charge_pump_uv = 1'b0;
		tick(10);
		chk(foe, 1'b0);
		chk(de, 1'b1);
		cfg.overvoltage_lock_option = 1'b1;
		flt.overvoltage = 1'b1;
		tick(5);
		rd_chk(8'h93, 16'h0200);
		chk(la, 1'b1);
		flt.overvoltage = 1'b0;
		tick(250);
		rd_chk(8'h93, 16'h0000);
		chk(de, 1'b1);
		flt.sync_loss = 7'h08;
		tick(5);
		rd_chk(8'h94, 16'h0008);
		chk(la, 1'b1);
		chk(foe, 1'b1);
		flt.sync_loss = 7'h00;
		tick(250);
		rd_chk(8'h94, 16'h0000);
		chk(la, 1'b0);
		cfg.overcurrent_latch_option = 1'b1;
		flt.overcurrent_protection = 6'h01;
		tick(100);
		chk(de, 1'b1);
		tick(100);
		chk(de, 1'b0);
		flt.overcurrent_protection = 6'h00;
		tick(300);
		rd_chk(8'h93, 16'h0001);
		duty(9'h005);
		duty(9'h0c8);
		rd_chk(8'h93, 16'h0000);
		chk(de, 1'b1);
		cfg.overcurrent_latch_option = 1'b0;
		flt.overcurrent_protection = 6'h20;
		tick(200);
		chk(la, 1'b1);
		flt.overcurrent_protection = 6'h00;
		tick(250);
		rd_chk(8'h93, 16'h0000);
		chk(de, 1'b1);
		flt.low_side_sense = 1'b1;
		tick(100);
		chk(cl, 1'b0);
		flt.low_side_sense = 1'b0;
		tick(5);
		flt.low_side_sense = 1'b1;
		tick(200);
		chk(cl, 1'b1);
		flt.low_side_sense = 1'b0;
		tick(10);
		finish_test();
	end
endmodule : fan_speed_curve_and_fault_logic_bench
`default_nettype wire
